/* File: bench/meb_bus_pins_checker.sv */
// concurrent checks on the pins of the expansion bus block
`timescale 1ns/1ps
module meb_bus_pins_checker (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       mode_pins_oe,
    input wire logic       mode_pins_pulldown,
    input wire logic [2:0] op_mode,
    input wire logic       rw_pin_enable_bit,
    input wire logic       low_strobe_enable_bit,
    input wire logic       queue_track_enable,
    input wire logic [15:0] gpio_dir,
    input wire logic [7:0] port_a_oe,
    input wire logic [7:0] port_b_oe,
    input wire logic       bus_clock_out,
    input wire logic       rw_out,
    input wire logic       rw_oe,
    input wire logic       rw_pullup,
    input wire logic       low_strobe_oe,
    input wire logic       low_strobe_pullup,
    input wire logic       data_bus_enable_n,
    input wire logic       data_bus_enable_oe,
    input wire logic       data_bus_enable_pullup,
    input wire logic       debug_wire_oe,
    input wire logic       debug_wire_pullup,
    input wire logic       req_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ****************
    // pin assertions
    // ****************
    a_reset_quiet: assert property (disable iff (1'h0) rst ##1 rst |->
        mode_pins_pulldown && !mode_pins_oe && !rw_oe && !low_strobe_oe) else $error("pins driven in reset");
    a_reset_pullups: assert property (disable iff (1'h0) rst ##1 rst |->
        rw_pullup && low_strobe_pullup && data_bus_enable_pullup) else $error("pullup off in reset");
    a_rw_gated: assert property ((!rw_pin_enable_bit)[*3] |-> !rw_oe)
        else $error("rw driven while disabled");
    a_strobe_gated: assert property ((!low_strobe_enable_bit)[*3] |-> !low_strobe_oe)
        else $error("strobe driven while disabled");
    a_dbe_high: assert property (!data_bus_enable_n |-> bus_clock_out)
        else $error("dbe low outside clock high");
    a_dbe_short: assert property ($fell(data_bus_enable_n) |=> data_bus_enable_n)
        else $error("dbe held past last quarter");
    a_dbe_single: assert property (!op_mode[0] |-> !data_bus_enable_oe && data_bus_enable_pullup)
        else $error("dbe not pulled up in single chip");
    a_gpio_single: assert property (!op_mode[0] && !$past(rst) && !$past(rst, 2) && $stable(gpio_dir)
        |-> {port_a_oe, port_b_oe} == gpio_dir) else $error("port direction not gpio");
    a_queue_drive: assert property (queue_track_enable ##1 queue_track_enable |->
        mode_pins_oe && !mode_pins_pulldown) else $error("queue tracking not driven");
    a_rw_steady: assert property (bus_clock_out && $past(bus_clock_out) && rw_oe |-> $stable(rw_out))
        else $error("rw moved in clock high");
    a_mode_held: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(op_mode))
        else $error("mode changed after reset");
    a_debug_pullup: assert property (!debug_wire_oe |-> debug_wire_pullup)
        else $error("debug wire input not pulled up");
    c_done: cover property (req_done);
    c_dbe: cover property ($fell(data_bus_enable_n));
    c_queue: cover property ($rose(mode_pins_oe));
endmodule : meb_bus_pins_checker

bind meb_bus_pins meb_bus_pins_checker chk (.*);

/* File: bench/meb_ext_mem.sv */
// byte memory on the far side of the multiplexed bus
`timescale 1ns/1ps
module meb_ext_mem (
    input wire logic       clk,
    input wire logic       wide,
    input wire logic       bus_clock_out,
    input wire logic       rw_pin,
    input wire logic       data_bus_enable_n,
    input wire logic       low_byte_strobe_in,
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_b_out,
    output logic [7:0]     port_a_in,
    output logic [7:0]     port_b_in,
    output logic           strobe_seen
);
    logic [7:0]  mem [256];
    logic [15:0] addr_q = 16'h0;
    logic [15:0] last_q = 16'h0;
    wire         rd = !data_bus_enable_n && rw_pin;
    // clocked capture: samples pins each clock while bus clock low, holds while high
    always @(posedge clk) begin
        if (!bus_clock_out) addr_q <= {port_a_out, port_b_out};
        if (bus_clock_out && !rw_pin) begin
            mem[addr_q[7:0]] <= port_a_out;
            if (wide) mem[addr_q[7:0] | 8'h01] <= port_b_out;
        end
        if (bus_clock_out && (!rw_pin || rd)) strobe_seen <= low_byte_strobe_in;
        last_q <= {port_a_in, port_b_in};
    end
    // released lines show the inverse so stale data cannot pass
    assign port_a_in = rd ? mem[addr_q[7:0]] : ~last_q[15:8];
    assign port_b_in = (rd && wide) ? mem[addr_q[7:0] | 8'h01] : ~last_q[7:0];
endmodule : meb_ext_mem

/* File: bench/test_meb_bus_pins.sv */
// testbench for the expansion bus pin block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module test_meb_bus_pins;
    typedef struct packed {
        logic [2:0] m; logic w; logic b; logic [1:0] st;
        logic [15:0] a; logic [15:0] d; logic [1:0] s; logic dn;
    } meb_row_t;
    logic clk = 1'h0, rst = 1'h1, special_mode_select_pin = 1'h0, mode_select_a = 1'h0;
    logic mode_select_b = 1'h0, rw_pin_enable_bit = 1'h0, low_strobe_enable_bit = 1'h0;
    logic no_bus_enable_bit = 1'h0, queue_track_enable = 1'h0, tag_select = 1'h0;
    logic req_valid = 1'h0, req_write = 1'h0, byte_size_access = 1'h0, dbg_tx_go = 1'h0;
    logic [1:0] stretch_cycles = 2'h0;
    logic [3:0] queue_state = 4'h0;
    logic [15:0] req_addr = 16'h0, req_wdata = 16'h0, gpio_out = 16'hA5A5, gpio_dir = 16'h0F0F;
    logic [7:0] dbg_tx_byte = 8'h5A, port_a_in, port_b_in, port_a_out, port_a_oe, port_b_out;
    logic [7:0] port_b_oe, dbg_rx_byte;
    logic [15:0] req_rdata, gpio_in;
    logic [2:0] op_mode;
    logic mode_select_a_out, mode_select_b_out, mode_pins_oe, mode_pins_pulldown, req_done;
    logic bus_clock_out, rw_out, rw_oe, rw_pullup, low_byte_strobe_n, low_strobe_oe;
    logic low_strobe_pullup, data_bus_enable_n, data_bus_enable_oe, data_bus_enable_pullup;
    logic debug_wire_out, debug_wire_oe, debug_wire_pullup, dbg_rx_valid, instr_tag_high;
    logic instr_tag_low, strobe_seen;
    int checks = 0, failures = 0;
    // open-drain and pulled-up pins resolved from the enables
    wire debug_wire_in = debug_wire_oe ? debug_wire_out : 1'h1;
    wire low_byte_strobe_in = low_strobe_oe ? low_byte_strobe_n : 1'h1;
    wire rw_pin = rw_oe ? rw_out : 1'h1;
    wire wide = op_mode[1];
    meb_row_t rows [9] = '{
        {3'h7, 1'h1, 1'h0, 2'h0, 16'h0020, 16'h1234, 2'h2, 1'h1},
        {3'h7, 1'h0, 1'h0, 2'h3, 16'h0020, 16'h1234, 2'h2, 1'h1},
        {3'h5, 1'h0, 1'h0, 2'h0, 16'h0020, 16'h1234, 2'h0, 1'h1},
        {3'h5, 1'h1, 1'h0, 2'h1, 16'h0040, 16'hA5C3, 2'h0, 1'h1},
        {3'h7, 1'h0, 1'h0, 2'h0, 16'h0040, 16'hA5C3, 2'h2, 1'h1},
        {3'h7, 1'h1, 1'h1, 2'h0, 16'h0060, 16'h0011, 2'h3, 1'h1},
        {3'h7, 1'h1, 1'h1, 2'h0, 16'h0061, 16'h0022, 2'h2, 1'h1},
        {3'h4, 1'h1, 1'h0, 2'h0, 16'h0040, 16'hFFFF, 2'h0, 1'h0},
        {3'h7, 1'h0, 1'h0, 2'h0, 16'h0040, 16'hA5C3, 2'h2, 1'h1}};
    meb_bus_pins dut (.*);
    meb_ext_mem ext (.*);
    initial forever #25 clk = ~clk;
    always @(posedge clk) queue_state <= queue_state + 4'h1;
    // ****************
    // tasks
    // ****************
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic do_reset(input logic [2:0] m);
        rst <= 1'h1;
        {special_mode_select_pin, mode_select_b, mode_select_a} <= m;
        {rw_pin_enable_bit, low_strobe_enable_bit, queue_track_enable} <= 3'h0;
        repeat (5) @(posedge clk);
        `CHK({rw_oe, low_strobe_oe, mode_pins_pulldown, rw_pullup}, 4'h3)
        rst <= 1'h0;
        repeat (4) @(posedge clk);
        `CHK(op_mode, m)
        `CHK(data_bus_enable_oe, m[0])
        {rw_pin_enable_bit, low_strobe_enable_bit, queue_track_enable} <= 3'h7;
        {special_mode_select_pin, mode_select_b, mode_select_a} <= 3'h0;
    endtask : do_reset
    task automatic xfer(input meb_row_t r, output logic dn, output logic [15:0] rd);
        int n;
        {stretch_cycles, req_write, byte_size_access} <= {r.st, r.w, r.b};
        {req_addr, req_wdata, req_valid} <= {r.a, r.d, 1'h1};
        dn = 1'h0;
        for (n = 0; n < 60 && !dn; n++) begin
            @(posedge clk);
            dn = (req_done === 1'h1);
            rd = req_rdata;
        end
        req_valid <= 1'h0;
        @(posedge clk);
    endtask : xfer
    // ****************
    // main sequence
    // ****************
    initial begin
        logic [2:0] cur;
        logic [15:0] rd;
        logic dn;
        int i;
        cur = 3'h0;
        for (i = 0; i < 9; i++) begin
            if (rows[i].m !== cur) do_reset(rows[i].m);
            cur = rows[i].m;
            xfer(rows[i], dn, rd);
            `CHK(dn, rows[i].dn)
            if (dn && !rows[i].w) `CHK(rd, rows[i].d)
            if (rows[i].s[1]) `CHK(strobe_seen, rows[i].s[0])
            $display("row %0d finished", i);
        end
        dbg_tx_go <= 1'h1;
        @(posedge clk);
        dbg_tx_go <= 1'h0;
        dn = 1'h0;
        for (i = 0; i < 40 && !dn; i++) begin
            @(posedge clk);
            dn = (debug_wire_oe === 1'h1);
        end
        `CHK(dn, 1'h1)
        $display("debug wire test finished");
        wrap_up();
    end
    initial begin
        #500000;
        failures++;
        wrap_up();
    end
endmodule : test_meb_bus_pins

/* File: core/meb_bus_pins.sv */
// pin control for the multiplexed external expansion bus
// How it works
// - mode straps are sampled while reset is held; mode latched from them
// - mode pins pulled down in reset, later become queue tracking outputs
// - after reset special pin is debug wire or high instruction tag input
// - debug wire sends and receives self-timed bits, always pulled up as input
// - single-chip: ports A/B are general I/O; expanded: address and data
// - wide mode: A carries addr/data high, B carries addr/data low
// - narrow mode: A and B give address; 8-bit data shares port A only
// - narrow 16-bit transfer is two byte cycles, high byte then low
// - read/write pin is pulled-up input until its enable bit is set
// - low strobe pin is pulled-up input until its enable bit is set
// - low strobe active low, equals xnor of address bit 0 and size
// - special expanded modes: low strobe pin also low instruction tag input
// - queue tracking outputs time-multiplex the execution queue state
// - data bus enable driven low while bus clock high during an external bus access
// - stretched access: enable asserted only in last quarter of last cycle
// - data bus enable controlled by its bit, on out of reset when expanded
// - single-chip: data bus enable pin pulled up during and after reset
// - bus clock runs at half rate out of reset, may be stretched
`timescale 1ns/1ps
module meb_bus_pins
    import meb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    // strap and mode pins
    input  wire logic       special_mode_select_pin,
    input  wire logic       mode_select_a,
    input  wire logic       mode_select_b,
    output logic            mode_select_a_out,
    output logic            mode_select_b_out,
    output logic            mode_pins_oe,
    output logic            mode_pins_pulldown,
    output logic [2:0]      op_mode,
    // software configuration bits
    input  wire logic       rw_pin_enable_bit,
    input  wire logic       low_strobe_enable_bit,
    input  wire logic       no_bus_enable_bit,
    input  wire logic       queue_track_enable,
    input  wire logic       tag_select,
    input  wire logic [1:0] stretch_cycles,
    // internal queue state, paired per bus cycle
    input  wire logic [3:0] queue_state,
    // internal bus request
    input  wire logic       req_valid,
    input  wire logic       req_write,
    input  wire logic       byte_size_access,
    input  wire logic [15:0] req_addr,
    input  wire logic [15:0] req_wdata,
    output logic            req_done,
    output logic [15:0]     req_rdata,
    // general purpose values for ports A/B in single-chip modes
    input  wire logic [15:0] gpio_out,
    input  wire logic [15:0] gpio_dir,
    output logic [15:0]     gpio_in,
    // port pins
    input  wire logic [7:0] port_a_in,
    output logic [7:0]      port_a_out,
    output logic [7:0]      port_a_oe,
    input  wire logic [7:0] port_b_in,
    output logic [7:0]      port_b_out,
    output logic [7:0]      port_b_oe,
    output logic            bus_clock_out,
    output logic            rw_out,
    output logic            rw_oe,
    output logic            rw_pullup,
    input  wire logic       low_byte_strobe_in,
    output logic            low_byte_strobe_n,
    output logic            low_strobe_oe,
    output logic            low_strobe_pullup,
    output logic            data_bus_enable_n,
    output logic            data_bus_enable_oe,
    output logic            data_bus_enable_pullup,
    // debug wire and tags
    input  wire logic       debug_wire_in,
    output logic            debug_wire_out,
    output logic            debug_wire_oe,
    output logic            debug_wire_pullup,
    input  wire logic       dbg_tx_go,
    input  wire logic [7:0] dbg_tx_byte,
    output logic            dbg_rx_valid,
    output logic [7:0]      dbg_rx_byte,
    output logic            instr_tag_high,
    output logic            instr_tag_low
);
    // ***************************************************************
    // pin synchronisers
    // ***************************************************************
    logic [2:0]  strap_s1_q, strap_s2_q;
    logic [7:0]  pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
    logic        lstr_s1_q, lstr_s2_q, dbg_s1_q, dbg_s2_q;

    always_ff @(posedge clk) begin
        strap_s1_q <= {special_mode_select_pin, mode_select_b, mode_select_a};
        strap_s2_q <= strap_s1_q;
        pa_s1_q    <= port_a_in;
        pa_s2_q    <= pa_s1_q;
        pb_s1_q    <= port_b_in;
        pb_s2_q    <= pb_s1_q;
        lstr_s1_q  <= low_byte_strobe_in;
        lstr_s2_q  <= lstr_s1_q;
        dbg_s1_q   <= debug_wire_in;
        dbg_s2_q   <= dbg_s1_q;
    end

    // ***************************************************************
    // mode capture while reset held
    // ***************************************************************
    meb_mode_t mode_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= meb_mode_t'(strap_s2_q);
        end
    end

    function automatic logic is_expanded(input meb_mode_t m);
        return (m == MEB_SPEC_NARROW) || (m == MEB_SPEC_WIDE) ||
               (m == MEB_NORM_NARROW) || (m == MEB_NORM_WIDE);
    endfunction : is_expanded

    function automatic logic is_narrow(input meb_mode_t m);
        return (m == MEB_SPEC_NARROW) || (m == MEB_NORM_NARROW);
    endfunction : is_narrow

    logic exp_w, narrow_w, special_w;
    assign exp_w     = is_expanded(mode_q);
    assign narrow_w  = is_narrow(mode_q);
    assign special_w = !mode_q[2];

    // ***************************************************************
    // bus cycle sequencer: bus clock low for addr, high for data
    // ***************************************************************
    meb_phase_t phase_q;
    logic [1:0]  str_q;
    logic        second_q;
    logic        write_q, size8_q, bus_clock_out_q;
    logic [15:0] addr_q, wdata_q, rdata_q;
    logic        done_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q  <= MEB_IDLE;
            str_q    <= MEB_STRETCH_RESET;
            second_q <= 1'b0;
            write_q  <= 1'b0;
            size8_q  <= 1'b0;
            addr_q   <= 16'h0000;
            wdata_q  <= 16'h0000;
            rdata_q  <= 16'h0000;
            done_q   <= 1'b0;
            bus_clock_out_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (phase_q)
                MEB_IDLE: begin
                    bus_clock_out_q <= ~bus_clock_out_q;
                    if (bus_clock_out_q && req_valid && exp_w && !req_done) begin
                        write_q  <= req_write;
                        size8_q  <= byte_size_access;
                        addr_q   <= req_addr;
                        wdata_q  <= req_wdata;
                        second_q <= 1'b0;
                        phase_q  <= MEB_ADDR;
                    end
                end
                MEB_ADDR: begin
                    bus_clock_out_q  <= 1'b1;
                    str_q   <= stretch_cycles;
                    phase_q <= (stretch_cycles == 2'h0) ? MEB_LAST : MEB_STRLO;
                end
                MEB_STRLO: begin
                    phase_q <= MEB_STRHI;
                end
                MEB_STRHI: begin
                    str_q   <= str_q - 2'h1;
                    phase_q <= (str_q == 2'h1) ? MEB_LAST : MEB_STRLO;
                end
                MEB_LAST: begin
                    bus_clock_out_q  <= 1'b0;
                    phase_q <= MEB_DATA;
                end
                MEB_DATA: phase_q <= MEB_SYNC1;
                MEB_SYNC1: phase_q <= MEB_SYNC2;
                MEB_SYNC2: begin
                    if (narrow_w) begin
                        if (!size8_q && !second_q) begin
                            rdata_q[15:8] <= pa_s2_q;
                        end else if (!size8_q || addr_q[0]) begin
                            rdata_q[7:0] <= pa_s2_q;
                        end else begin
                            rdata_q[15:8] <= pa_s2_q;
                        end
                    end else begin
                        rdata_q <= {pa_s2_q, pb_s2_q};
                    end
                    if (!size8_q && narrow_w && !second_q) begin
                        second_q <= 1'b1;
                        addr_q   <= addr_q | 16'h0001;
                        phase_q  <= MEB_ADDR;
                    end else begin
                        done_q  <= 1'b1;
                        phase_q <= MEB_IDLE;
                    end
                end
            endcase
        end
    end

    logic bus_clock_out_hi_w;
    assign bus_clock_out_hi_w = (phase_q == MEB_STRLO) || (phase_q == MEB_STRHI) ||
                       (phase_q == MEB_LAST);

    // ***************************************************************
    // pin drive, registered so every output is a flop
    // ***************************************************************
    logic [7:0] wbyte_w;
    assign wbyte_w = (second_q || (size8_q && addr_q[0])) ? wdata_q[7:0] : wdata_q[15:8];

    always_ff @(posedge clk) begin
        if (rst) begin
            port_a_out <= MEB_PORT_RESET;
            port_a_oe  <= MEB_PORT_RESET;
            port_b_out <= MEB_PORT_RESET;
            port_b_oe  <= MEB_PORT_RESET;
        end else if (!exp_w) begin
            port_a_out <= gpio_out[15:8];
            port_a_oe  <= gpio_dir[15:8];
            port_b_out <= gpio_out[7:0];
            port_b_oe  <= gpio_dir[7:0];
        end else begin
            port_b_oe <= 8'hFF;
            if (bus_clock_out_hi_w && narrow_w) begin
                port_b_out <= addr_q[7:0];
            end else if (bus_clock_out_hi_w) begin
                port_b_out <= wdata_q[7:0];
                port_b_oe  <= {8{write_q}};
            end else begin
                port_b_out <= addr_q[7:0];
            end
            if (bus_clock_out_hi_w) begin
                port_a_out <= narrow_w ? wbyte_w : wdata_q[15:8];
                port_a_oe  <= {8{write_q}};
            end else begin
                port_a_out <= addr_q[15:8];
                port_a_oe  <= 8'hFF;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_clock_out          <= 1'b0;
            rw_out                 <= 1'b1;
            rw_oe                  <= 1'b0;
            low_byte_strobe_n      <= 1'b1;
            low_strobe_oe          <= 1'b0;
            data_bus_enable_n      <= 1'b1;
            data_bus_enable_oe     <= 1'b0;
            req_done               <= 1'b0;
            req_rdata              <= 16'h0000;
            gpio_in                <= 16'h0000;
        end else begin
            bus_clock_out      <= (phase_q == MEB_IDLE) ? bus_clock_out_q : bus_clock_out_hi_w;
            rw_out             <= !(phase_q != MEB_IDLE && write_q);
            rw_oe              <= rw_pin_enable_bit;
            low_byte_strobe_n  <= ~(addr_q[0] ~^ size8_q);
            low_strobe_oe      <= low_strobe_enable_bit && !(special_w && exp_w && tag_select);
            // stretched: only the final high phase asserts the enable
            data_bus_enable_n  <= !(phase_q == MEB_LAST);
            data_bus_enable_oe <= exp_w && !no_bus_enable_bit;
            req_done           <= done_q;
            req_rdata          <= rdata_q;
            gpio_in            <= {pa_s2_q, pb_s2_q};
        end
    end

    // pullups: straps pulled down in reset, other inputs held high
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_pins_pulldown     <= 1'b1;
            rw_pullup              <= 1'b1;
            low_strobe_pullup      <= 1'b1;
            data_bus_enable_pullup <= 1'b1;
            op_mode                <= MEB_MODE_RESET;
        end else begin
            mode_pins_pulldown     <= 1'b0;
            rw_pullup              <= !rw_pin_enable_bit;
            low_strobe_pullup      <= !low_strobe_enable_bit || (special_w && exp_w && tag_select);
            data_bus_enable_pullup <= !exp_w;
            op_mode                <= mode_q;
        end
    end

    // ***************************************************************
    // queue tracking: two nibble halves alternate per bus clock half
    // ***************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_select_a_out <= 1'b0;
            mode_select_b_out <= 1'b0;
            mode_pins_oe      <= 1'b0;
        end else begin
            mode_pins_oe <= queue_track_enable;
            if (bus_clock_out) begin
                mode_select_a_out <= queue_state[0];
                mode_select_b_out <= queue_state[1];
            end else begin
                mode_select_a_out <= queue_state[2];
                mode_select_b_out <= queue_state[3];
            end
        end
    end

    // ***************************************************************
    // debug wire and instruction tags
    // ***************************************************************
    meb_dbg_if dbg_c ();
    assign dbg_c.pin_in  = dbg_s2_q;
    assign dbg_c.tx_go   = dbg_tx_go && !tag_select;
    assign dbg_c.tx_byte = dbg_tx_byte;

    meb_dbg_wire u_dbg (
        .clk (clk),
        .rst (rst),
        .dbg (dbg_c.wire_end)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            debug_wire_out <= 1'b1;
            debug_wire_oe  <= 1'b0;
            debug_wire_pullup <= 1'b1;
            dbg_rx_valid   <= 1'b0;
            dbg_rx_byte    <= 8'h00;
            instr_tag_high <= 1'b0;
            instr_tag_low  <= 1'b0;
        end else begin
            debug_wire_out <= 1'b0;
            debug_wire_oe  <= dbg_c.drive_low;
            debug_wire_pullup <= !dbg_c.drive_low;
            dbg_rx_valid   <= dbg_c.rx_valid && !tag_select;
            dbg_rx_byte    <= dbg_c.rx_byte;
            instr_tag_high <= tag_select && !dbg_s2_q;
            instr_tag_low  <= tag_select && special_w && exp_w && !lstr_s2_q;
        end
    end
endmodule : meb_bus_pins

/* File: core/meb_dbg_if.sv */
// carrier between the top and the debug wire serialiser
`timescale 1ns/1ps
interface meb_dbg_if;
    logic       pin_in;
    logic       drive_low;
    logic       tx_go;
    logic [7:0] tx_byte;
    logic       tx_busy;
    logic       rx_valid;
    logic [7:0] rx_byte;
    modport host (input  tx_busy, rx_valid, rx_byte, drive_low,
                  output pin_in, tx_go, tx_byte);
    modport wire_end (output tx_busy, rx_valid, rx_byte, drive_low,
                      input  pin_in, tx_go, tx_byte);
endinterface : meb_dbg_if

/* File: core/meb_dbg_wire.sv */
// self-timed single wire debug serialiser, lsb first, low pulse width codes the bit
`timescale 1ns/1ps
module meb_dbg_wire
    import meb_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    meb_dbg_if.wire_end dbg
);
    logic [5:0] tx_cnt_q;
    logic [3:0] tx_bit_q;
    logic [7:0] tx_sh_q;
    logic [5:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic       rx_prev_q;
    logic       rx_valid_q;

    // ***************************************************************
    // transmit: a 0 holds the wire low all but the last clock of a bit, a 1 only the first half bit
    // ***************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_cnt_q <= 6'h00;
            tx_bit_q <= 4'h0;
            tx_sh_q  <= 8'h00;
        end else if (tx_bit_q == 4'h0) begin
            if (dbg.tx_go) begin
                tx_sh_q  <= dbg.tx_byte;
                tx_bit_q <= 4'h8;
                tx_cnt_q <= MEB_DBG_BIT_CYC;
            end
        end else if (tx_cnt_q == 6'h01) begin
            tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q <= tx_bit_q - 4'h1;
            tx_cnt_q <= MEB_DBG_BIT_CYC;
        end else begin
            tx_cnt_q <= tx_cnt_q - 6'h01;
        end
    end
    assign dbg.tx_busy   = (tx_bit_q != 4'h0);
    assign dbg.drive_low = dbg.tx_busy && ((tx_cnt_q > MEB_DBG_SAMPLE_CYC) ||
                           (!tx_sh_q[0] && tx_cnt_q > 6'h01));

    // ***************************************************************
    // receive: falling edge starts a bit, level at mid bit is the value
    // ***************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_prev_q  <= 1'b1;
            rx_cnt_q   <= 6'h00;
            rx_bit_q   <= 4'h0;
            rx_sh_q    <= 8'h00;
            rx_valid_q <= 1'b0;
        end else begin
            rx_prev_q  <= dbg.pin_in;
            rx_valid_q <= 1'b0;
            if (rx_cnt_q == 6'h00) begin
                if (rx_prev_q && !dbg.pin_in && !dbg.tx_busy) begin
                    rx_cnt_q <= MEB_DBG_SAMPLE_CYC;
                end
            end else if (rx_cnt_q == 6'h01) begin
                rx_cnt_q <= 6'h00;
                rx_sh_q  <= {dbg.pin_in, rx_sh_q[7:1]};
                if (rx_bit_q == 4'h7) begin
                    rx_bit_q   <= 4'h0;
                    rx_valid_q <= 1'b1;
                end else begin
                    rx_bit_q <= rx_bit_q + 4'h1;
                end
            end else begin
                rx_cnt_q <= rx_cnt_q - 6'h01;
            end
        end
    end
    assign dbg.rx_valid = rx_valid_q;
    assign dbg.rx_byte  = rx_sh_q;
endmodule : meb_dbg_wire

/* File: core/meb_pkg.sv */
// shared constants and types for the multiplexed external bus pin block
package meb_pkg;
    // ***************************************************************
    // operating modes from the strap pins {special_n, mode_b, mode_a}
    // ***************************************************************
    typedef enum logic [2:0] {
        MEB_SPEC_SINGLE = 3'h0,
        MEB_SPEC_NARROW = 3'h1,
        MEB_SPEC_PERIPH = 3'h2,
        MEB_SPEC_WIDE   = 3'h3,
        MEB_NORM_SINGLE = 3'h4,
        MEB_NORM_NARROW = 3'h5,
        MEB_NORM_RSVD   = 3'h6,
        MEB_NORM_WIDE   = 3'h7
    } meb_mode_t;

    // ***************************************************************
    // bus cycle phases, one per system clock
    // ***************************************************************
    typedef enum logic [2:0] {
        MEB_IDLE   = 3'h0,
        MEB_ADDR   = 3'h1,
        MEB_DATA   = 3'h2,
        MEB_STRLO  = 3'h3,
        MEB_STRHI  = 3'h4,
        MEB_LAST   = 3'h5,
        MEB_SYNC1  = 3'h6,
        MEB_SYNC2  = 3'h7
    } meb_phase_t;

    localparam logic [2:0] MEB_MODE_RESET     = 3'h0;
    localparam logic [7:0] MEB_PORT_RESET     = 8'h00;
    localparam logic [1:0] MEB_STRETCH_RESET  = 2'h0;
    // debug wire bit time in nanoseconds, converted to system clocks
    localparam int         MEB_DBG_BIT_NS     = 800;
    localparam int         MEB_CLK_NS         = 50;
    localparam logic [5:0] MEB_DBG_BIT_CYC    = 6'((MEB_DBG_BIT_NS + MEB_CLK_NS - 1) / MEB_CLK_NS);
    localparam logic [5:0] MEB_DBG_SAMPLE_CYC = 6'(MEB_DBG_BIT_CYC / 6'h2);
endpackage : meb_pkg
